// ==== core/swp_pkg.sv ====
// Shared constants and carrier types for the sector write-protect pin block
package swp_pkg;

	localparam int unsigned ROW_W = 11;
	localparam int unsigned COL_W = 9;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NUM_SECTORS = 16;
	localparam int unsigned SECTOR_W = 4;
	localparam int unsigned SECTOR_LSB = 16;
	localparam logic [SECTOR_W-1:0] TOP_SECTOR = 4'hf;

	localparam logic [ROW_W-1:0] ROW_RESET = 11'h000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 20'h00000;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [NUM_SECTORS-1:0] LOCK_RESET = 16'h0000;

	// Pins of the multiplexed programming port, all taken as synchronous
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_strobe_n;
		logic row_col_sel;
		logic [ROW_W-1:0] addr_pins;
	} swp_pins_s;

	// Write captured at the rising strobe edge
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} swp_wr_s;

	// Protection verdict for one write
	typedef struct packed {
		logic allow;
		logic hw_block;
		logic reg_block;
	} swp_verdict_s;

endpackage

// ==== core/swp_addr_latch.sv ====
// Row and column address capture for the multiplexed programming port
`timescale 1ns/10ps
`default_nettype none

module swp_addr_latch
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Port pins
	input wire logic row_col_sel,
	input wire logic [swp_pkg::ROW_W-1:0] addr_pins,
	input wire logic capture,
	// Assembled addresses
	output logic [swp_pkg::ADDR_W-1:0] live_addr,
	output logic [swp_pkg::ADDR_W-1:0] held_addr
);

	logic [swp_pkg::ROW_W-1:0] row_d, row_q;
	logic [swp_pkg::ADDR_W-1:0] held_d, held_q;

	////////////////////////////////////////////////////////////////////////////////
	// Row half follows the pins while row select is high, then freezes
	always_comb
	begin
		row_d = row_q;
		if (row_col_sel)
			row_d = addr_pins;
		held_d = held_q;
		if (capture)
			held_d = live_addr;
	end

	// Column half is read straight off the shared pins once row select drops
	assign live_addr = {addr_pins[swp_pkg::COL_W-1:0], row_q};
	assign held_addr = held_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			row_q <= swp_pkg::ROW_RESET;
			held_q <= swp_pkg::ADDR_RESET;
		end
		else
		begin
			row_q <= row_d;
			held_q <= held_d;
		end
	end

endmodule

`default_nettype wire

// ==== core/swp_protect_gate.sv ====
// Hardware and register protection verdict for one sector
`timescale 1ns/10ps
`default_nettype none

module swp_protect_gate
(
	// Target
	input wire logic [swp_pkg::SECTOR_W-1:0] sector,
	// Protection sources
	input wire logic [swp_pkg::NUM_SECTORS-1:0] sector_lock,
	input wire logic top_sector_lock_n,
	input wire logic write_protect_n,
	// Verdict
	output swp_pkg::swp_verdict_s verdict
);

	logic is_top;
	logic hw_pin_n;

	always_comb
	begin
		is_top = (sector == swp_pkg::TOP_SECTOR);
		// Top sector answers only to its own pin, the rest only to the general pin
		hw_pin_n = is_top ? top_sector_lock_n : write_protect_n;
		verdict.hw_block = !hw_pin_n;
		verdict.reg_block = sector_lock[sector];
		verdict.allow = hw_pin_n && !sector_lock[sector];
	end

endmodule

`default_nettype wire

// ==== core/swp_pins.sv ====
// Top of the write-protect gating and multiplexed programming-port pin logic
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Top lock low rejects sector 15 writes
// - Top lock high still honours its register lock
// - Protect pins never touch lock registers
// - Write-protect low rejects sectors 0 to 14
// - Write-protect high still honours register locks
// - Low address bits share pins, row-select captured
// - Address held internally after write cycle
// - Host drives write data on data_pins
// - Device drives read results on data_pins
// - Data pins float when deselected or disabled
// - Write data captured into holding register
// - Row select picks row or column half
// - Capture on rising edge of write strobe
module swp_pins
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Programming port control and address pins
	input wire swp_pkg::swp_pins_s pins,
	// Data pins, split three ways
	input wire logic [swp_pkg::DATA_W-1:0] data_pins_i,
	output logic [swp_pkg::DATA_W-1:0] data_pins_o,
	output logic data_pins_oe,
	// Hardware protect inputs
	input wire logic top_sector_lock_n,
	input wire logic write_protect_n,
	// Lock registers kept elsewhere
	input wire logic [swp_pkg::NUM_SECTORS-1:0] sector_lock,
	output logic [swp_pkg::NUM_SECTORS-1:0] lock_status,
	// Array side
	input wire logic [swp_pkg::DATA_W-1:0] array_rd_data,
	output logic [swp_pkg::ADDR_W-1:0] array_rd_addr,
	output swp_pkg::swp_wr_s array_wr,
	output logic wr_reject_hw,
	output logic wr_reject_lock
);

	typedef enum logic [1:0] {SWP_WR_IDLE, SWP_WR_LOW, SWP_WR_JUDGE} swp_wr_state_e;

	swp_wr_state_e wr_state_d, wr_state_q;
	logic strobe_rise;
	logic judging;
	logic [swp_pkg::ADDR_W-1:0] live_addr;
	logic [swp_pkg::ADDR_W-1:0] held_addr;
	logic [swp_pkg::DATA_W-1:0] wdata_d, wdata_q;
	swp_pkg::swp_verdict_s verdict;
	swp_pkg::swp_wr_s wr_d, wr_q;
	logic rej_hw_d, rej_hw_q;
	logic rej_lock_d, rej_lock_q;
	logic [swp_pkg::DATA_W-1:0] dout_d, dout_q;
	logic oe_d, oe_q;
	logic [swp_pkg::ADDR_W-1:0] rd_addr_d, rd_addr_q;
	logic [swp_pkg::NUM_SECTORS-1:0] lock_d, lock_q;

	////////////////////////////////////////////////////////////////////////////////
	// Write cycle sequencing
	// Low means the strobe was last seen low, so the state doubles as the edge
	// history; reset lands in idle, so a strobe held high at release is no edge
	always_comb
	begin
		wr_state_d = wr_state_q;
		strobe_rise = 1'b0;
		judging = 1'b0;
		unique case (wr_state_q)
			SWP_WR_IDLE:
			begin
				if (!pins.write_strobe_n)
					wr_state_d = SWP_WR_LOW;
			end
			SWP_WR_LOW:
			begin
				if (pins.write_strobe_n)
				begin
					// Only a selected chip accepts the strobe
					strobe_rise = !pins.chip_select_n;
					if (pins.chip_select_n)
						wr_state_d = SWP_WR_IDLE;
					else
						wr_state_d = SWP_WR_JUDGE;
				end
			end
			SWP_WR_JUDGE:
			begin
				// Verdict is taken now; the next strobe may already be low
				judging = 1'b1;
				if (pins.write_strobe_n)
					wr_state_d = SWP_WR_IDLE;
				else
					wr_state_d = SWP_WR_LOW;
			end
			default:
			begin
				// Unused code falls back to idle rather than locking up
				wr_state_d = SWP_WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_state_q <= SWP_WR_IDLE;
		else
			wr_state_q <= wr_state_d;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address capture
	swp_addr_latch u_addr
	(
		.clk(clk),
		.rst_n(rst_n),
		.row_col_sel(pins.row_col_sel),
		.addr_pins(pins.addr_pins),
		.capture(strobe_rise),
		.live_addr(live_addr),
		.held_addr(held_addr)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Data holding register
	always_comb
	begin
		wdata_d = wdata_q;
		if (strobe_rise)
		begin
			wdata_d = data_pins_i;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wdata_q <= swp_pkg::DATA_RESET;
		end
		else
		begin
			wdata_q <= wdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Protection verdict on the held address
	swp_protect_gate u_gate
	(
		.sector(held_addr[swp_pkg::ADDR_W-1:swp_pkg::SECTOR_LSB]),
		.sector_lock(sector_lock),
		.top_sector_lock_n(top_sector_lock_n),
		.write_protect_n(write_protect_n),
		.verdict(verdict)
	);

	// Pins are judged one cycle after the strobe, on the held copy, so a host
	// that moves address or data right after the edge cannot alter the target
	always_comb
	begin
		wr_d.valid = 1'b0;
		wr_d.addr = wr_q.addr;
		wr_d.data = wr_q.data;
		rej_hw_d = 1'b0;
		rej_lock_d = 1'b0;
		if (judging)
		begin
			wr_d.addr = held_addr;
			wr_d.data = wdata_q;
			if (verdict.allow)
				wr_d.valid = 1'b1;
			else if (verdict.hw_block)
				rej_hw_d = 1'b1;
			else
				rej_lock_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '{valid: 1'b0, addr: swp_pkg::ADDR_RESET, data: swp_pkg::DATA_RESET};
			rej_hw_q <= 1'b0;
			rej_lock_q <= 1'b0;
		end
		else
		begin
			wr_q <= wr_d;
			rej_hw_q <= rej_hw_d;
			rej_lock_q <= rej_lock_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read path
	always_comb
	begin
		rd_addr_d = live_addr;
		dout_d = array_rd_data;
		// Never drive while the host may be driving a write
		oe_d = !pins.chip_select_n && !pins.output_enable_n && pins.write_strobe_n;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_addr_q <= swp_pkg::ADDR_RESET;
			dout_q <= swp_pkg::DATA_RESET;
			oe_q <= 1'b0;
		end
		else
		begin
			rd_addr_q <= rd_addr_d;
			dout_q <= dout_d;
			oe_q <= oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lock status mirror, one flop per sector, fed only from the lock registers
	// Protect pins have no path in here, so they can never disturb what software sees
	for (genvar s = 0; s < swp_pkg::NUM_SECTORS; s = s + 1)
	begin : g_lock
		always_comb
		begin
			lock_d[s] = sector_lock[s];
		end

		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
				lock_q[s] <= swp_pkg::LOCK_RESET[s];
			else
				lock_q[s] <= lock_d[s];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign data_pins_o = dout_q;
	assign data_pins_oe = oe_q;
	assign array_rd_addr = rd_addr_q;
	assign array_wr = wr_q;
	assign wr_reject_hw = rej_hw_q;
	assign wr_reject_lock = rej_lock_q;
	assign lock_status = lock_q;

endmodule

`default_nettype wire

// ==== tb/swp_pins_checker.sv ====
// Port assertions for the write-protect pin block
`timescale 1ns/10ps
`default_nettype none
module swp_pins_checker
(
	// Ports watched
	input wire logic clk,
	input wire logic rst_n,
	input wire swp_pkg::swp_pins_s pins,
	input wire logic [7:0] data_pins_i,
	input wire logic [7:0] data_pins_o,
	input wire logic data_pins_oe,
	input wire logic top_sector_lock_n,
	input wire logic write_protect_n,
	input wire logic [15:0] sector_lock,
	input wire logic [15:0] lock_status,
	input wire logic [7:0] array_rd_data,
	input wire logic [19:0] array_rd_addr,
	input wire swp_pkg::swp_wr_s array_wr,
	input wire logic wr_reject_hw,
	input wire logic wr_reject_lock
);
	logic strobe_q;
	logic take;
	// History starts high so a strobe held high at release is no edge
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			strobe_q <= 1'b1;
		else
			strobe_q <= pins.write_strobe_n;
	assign take = !pins.chip_select_n && pins.write_strobe_n && !strobe_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_oe_off: assert property ((pins.chip_select_n || pins.output_enable_n) |=> !data_pins_oe)
		else $error("pins driven");
	chk_rd_data: assert property (data_pins_oe |-> data_pins_o == $past(array_rd_data))
		else $error("read data");
	chk_lock_copy: assert property (rst_n |=> lock_status == $past(sector_lock))
		else $error("lock status");
	chk_wr_answer: assert property (take |-> ##2 (array_wr.valid || wr_reject_hw || wr_reject_lock))
		else $error("no verdict");
	chk_top_hw: assert property (take && pins.addr_pins[8:5] == 4'hf ##1 !top_sector_lock_n |=> wr_reject_hw)
		else $error("top not blocked");
	chk_rest_hw: assert property (take && pins.addr_pins[8:5] != 4'hf ##1 !write_protect_n |=> wr_reject_hw)
		else $error("sector not blocked");
	chk_wr_data: assert property (take |-> ##2 (!array_wr.valid || array_wr.data == $past(data_pins_i, 2)))
		else $error("write data");
	chk_reg_lock: assert property (array_wr.valid |-> ($past(sector_lock) >> array_wr.addr[19:16]) % 2 == 0)
		else $error("locked written");
endmodule
bind swp_pins swp_pins_checker chk_i (.clk(clk), .rst_n(rst_n), .pins(pins), .data_pins_i(data_pins_i),
	.data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe), .top_sector_lock_n(top_sector_lock_n),
	.write_protect_n(write_protect_n), .sector_lock(sector_lock), .lock_status(lock_status),
	.array_rd_data(array_rd_data), .array_rd_addr(array_rd_addr), .array_wr(array_wr),
	.wr_reject_hw(wr_reject_hw), .wr_reject_lock(wr_reject_lock));
`default_nettype wire

// ==== tb/swp_host.sv ====
// Programmer model driving the multiplexed port
`timescale 1ns/10ps
`default_nettype none
module swp_host
(
	// Port pins
	input wire logic clk,
	input wire logic [7:0] data_pins_o,
	input wire logic data_pins_oe,
	output swp_pkg::swp_pins_s pins,
	output logic [7:0] data_pins_i
);
	logic [7:0] drv = 8'h00;
	logic en = 1'b0;
	initial pins = '1;
	// Released lines show the inverse byte, so a stale copy cannot pass
	assign data_pins_i = data_pins_oe ? data_pins_o : en ? drv : ~drv;
	task automatic put(input logic [3:0] c, input logic [10:0] a);
		@(posedge clk);
		pins <= {c, a};
	endtask
	task automatic rd(input logic [19:0] a);
		put(4'h7, a[10:0]);
		put(4'h2, {2'h0, a[19:11]});
	endtask
	task automatic wr(input logic [19:0] a, input logic [7:0] d);
		put(4'hf, a[10:0]);
		put(4'h4, {2'h0, a[19:11]});
		drv <= d;
		en <= 1'b1;
		put(4'h6, {2'h0, a[19:11]});
		put(4'hf, ~a[10:0]);
		en <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/swp_pins_tb.sv ====
// Self-checking bench for the write-protect pin block
`timescale 1ns/10ps
`default_nettype none
module swp_pins_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tl_n = 1'b1;
	logic wp_n = 1'b1;
	logic [15:0] lk = 16'h0000;
	logic [7:0] di, dout, rdat;
	logic oe, rj_hw, rj_lk;
	logic [15:0] lst;
	logic [19:0] raddr;
	swp_pkg::swp_pins_s pins;
	swp_pkg::swp_wr_s wr;
	int err_total = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	// Array stand-in whose contents follow from the address
	assign rdat = raddr[7:0] ^ raddr[19:12];
	swp_host swp_host_i (.clk(clk), .data_pins_o(dout), .data_pins_oe(oe), .pins(pins), .data_pins_i(di));
	swp_pins swp_pins_i (.clk(clk), .rst_n(rst_n), .pins(pins), .data_pins_i(di), .data_pins_o(dout),
		.data_pins_oe(oe), .top_sector_lock_n(tl_n), .write_protect_n(wp_n), .sector_lock(lk),
		.lock_status(lst), .array_rd_data(rdat), .array_rd_addr(raddr), .array_wr(wr),
		.wr_reject_hw(rj_hw), .wr_reject_lock(rj_lk));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("%0d checks, %0d wrong", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic t_read;
		swp_host_i.rd(20'h5a3c7);
		repeat (2) @(posedge clk);
		#1;
		check(oe, 1'b1);
		check(raddr, 20'h5a3c7);
		check(dout, 8'hc7 ^ 8'h5a);
		// Selected with outputs disabled, enabled again, then deselected
		swp_host_i.put(4'h6, 11'h0b4);
		@(posedge clk);
		#1;
		check(oe, 1'b0);
		swp_host_i.put(4'h2, 11'h0b4);
		@(posedge clk);
		#1;
		check(oe, 1'b1);
		swp_host_i.put(4'ha, 11'h000);
		@(posedge clk);
		#1;
		check(oe, 1'b0);
		$display("read test done");
	endtask
	task automatic do_wr(input logic t, input logic w, input logic [15:0] l, input logic [19:0] a,
		input logic [7:0] d, input logic [2:0] e);
		logic [2:0] seen;
		seen = 3'h0;
		@(posedge clk);
		tl_n <= t;
		wp_n <= w;
		lk <= l;
		swp_host_i.wr(a, d);
		// Bounded wait for the verdict pulse
		for (int i = 0; i < 8 && seen == 3'h0; i++)
		begin
			@(posedge clk);
			#1;
			seen = {wr.valid, rj_hw, rj_lk};
		end
		// A verdict that never comes ends the run as a failure
		if (seen == 3'h0)
		begin
			err_total++;
			finish_test();
		end
		else
		begin
			check(seen, e);
			if (e[2])
			begin
				check(wr.addr, a);
				check(wr.data, d);
			end
			check(lst, l);
		end
	endtask
	task automatic t_protect;
		do_wr(1'b0, 1'b1, 16'h8000, 20'hf8123, 8'h5a, 3'h2);
		do_wr(1'b1, 1'b0, 16'h8000, 20'hf0456, 8'ha5, 3'h1);
		do_wr(1'b1, 1'b0, 16'h0000, 20'hfffff, 8'h3c, 3'h4);
		do_wr(1'b1, 1'b0, 16'h0000, 20'h37ff0, 8'h11, 3'h2);
		do_wr(1'b0, 1'b1, 16'h4000, 20'he0001, 8'hc3, 3'h1);
		do_wr(1'b0, 1'b1, 16'hfffe, 20'h0c0de, 8'h96, 3'h4);
		$display("protect test done");
	endtask
	// Strobe pulse with the chip deselected; sector 1 is locked, so a wrongly
	// taken strobe would show up as a lock reject
	task automatic t_deselect;
		logic [2:0] seen;
		seen = 3'h0;
		@(posedge clk);
		lk <= 16'h0002;
		swp_host_i.put(4'hf, 11'h345);
		swp_host_i.put(4'hc, 11'h024);
		swp_host_i.put(4'he, 11'h024);
		repeat (4)
		begin
			@(posedge clk);
			#1;
			seen = seen | {wr.valid, rj_hw, rj_lk};
		end
		check(seen, 3'h0);
		$display("deselect test done");
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_read();
		t_protect();
		t_deselect();
		finish_test();
	end
endmodule
`default_nettype wire
